// [shared/acs_regs.vh]
// register map and reset values of the adaptive clock sof capture block
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

`define ACS_ADDR_W 16
`define ACS_DATA_W 8

`define ACS_OFF_CAP_HIGH 16'hFFE3
`define ACS_OFF_CAP_LOW 16'hFFE4
`define ACS_OFF_FREQ_BYTE2 16'hFFF7
`define ACS_OFF_FREQ_BYTE1 16'hFFF8
`define ACS_OFF_FREQ_BYTE0 16'hFFF9

`define ACS_CNT_W 16
`define ACS_FREQ_W 24

`define ACS_BYTE0_LSB 0
`define ACS_BYTE1_LSB 8
`define ACS_BYTE2_LSB 16

`define ACS_RST_CAP 8'h00
`define ACS_RST_FREQ 8'h00
`define ACS_RST_CNT 16'h0000
`define ACS_RDATA_UNMAPPED 8'h00

`define ACS_SEL_ONE 1'b0
`define ACS_SEL_TWO 1'b1

`define ACS_REF_CLK_HZ 25000000

`endif

// [hw/acs_mclk_counter.v]
// free running master clock cycle counter with source select
`timescale 1ns/1ps
`include "acs_regs.vh"

module acs_mclk_counter #(
	parameter CNT_W = `ACS_CNT_W
) (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_mclk_one,
	input wire i_mclk_two,
	input wire i_sel,
	output wire o_tick,
	output wire [CNT_W-1:0] o_count
);

////////////////////////////////////////////////////////////////////////////////
// previous levels of both master clocks
reg prev_one_q;
reg prev_two_q;
reg [CNT_W-1:0] cnt_q;
wire rise_one;
wire rise_two;
wire tick;

assign rise_one = i_mclk_one & ~prev_one_q;
assign rise_two = i_mclk_two & ~prev_two_q;
assign tick = (i_sel == `ACS_SEL_TWO) ? rise_two : rise_one;

always @(posedge i_ref_clk) begin
	if (!i_nrst) begin
		prev_one_q <= 1'b0;
		prev_two_q <= 1'b0;
	end else begin
		prev_one_q <= i_mclk_one;
		prev_two_q <= i_mclk_two;
	end
end

////////////////////////////////////////////////////////////////////////////////
// increment and wrap
always @(posedge i_ref_clk) begin
	if (!i_nrst) begin
		cnt_q <= {CNT_W{1'b0}};
	end else if (tick) begin
		cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
	end
end

assign o_tick = tick;
assign o_count = cnt_q;

endmodule

// [hw/acs_sof_capture.v]
// sof capture of master clock count and second synthesizer frequency word
`timescale 1ns/1ps
`include "acs_regs.vh"

// Contract
// - 16-bit master clock counter, free running, wraps
// - sof copies counter into capture pair
// - counter clock selects master clock one or two
// - capture bytes read-only, sof-updated, reset zero
// - low byte FFE4, high byte FFE3
// - 24-bit frequency word drives second synthesizer
// - word bytes at FFF9, FFF8, third byte
module acs_sof_capture #(
	parameter CNT_W = `ACS_CNT_W,
	parameter FREQ_W = `ACS_FREQ_W
) (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_mclk_one,
	input wire i_mclk_two,
	input wire i_cnt_sel,
	input wire i_sof,
	input wire [15:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_wdata,
	output wire [7:0] o_rdata,
	output wire o_rvalid,
	output wire [FREQ_W-1:0] o_frequency_word,
	output wire o_freq_load,
	output wire [CNT_W-1:0] o_captured_count,
	output wire o_capture_pulse,
	output wire o_mclk_tick
);

////////////////////////////////////////////////////////////////////////////////
// declarations
wire [CNT_W-1:0] count;
wire tick;
reg [CNT_W-1:0] cap_q;
reg [CNT_W-1:0] cap_d;
reg cap_pulse_q;
reg [7:0] freq0_q;
reg [7:0] freq1_q;
reg [7:0] freq2_q;
reg [7:0] freq0_d;
reg [7:0] freq1_d;
reg [7:0] freq2_d;
reg freq_load_q;
reg freq_load_d;
reg [7:0] rdata_q;
reg [7:0] rdata_d;
reg rvalid_q;
wire hit_cap_high;
wire hit_cap_low;
wire hit_freq0;
wire hit_freq1;
wire hit_freq2;
wire wr_freq0;
wire wr_freq1;
wire wr_freq2;
wire [7:0] cap_low;
wire [7:0] cap_high;

////////////////////////////////////////////////////////////////////////////////
// master clock counter
// counter instance
acs_mclk_counter #(
	.CNT_W(CNT_W)
) u_counter (
	.i_ref_clk(i_ref_clk),
	.i_nrst(i_nrst),
	.i_mclk_one(i_mclk_one),
	.i_mclk_two(i_mclk_two),
	.i_sel(i_cnt_sel),
	.o_tick(tick),
	.o_count(count)
);

////////////////////////////////////////////////////////////////////////////////
// address decode
// capture and frequency byte offsets
assign hit_cap_high = (i_addr == `ACS_OFF_CAP_HIGH);
assign hit_cap_low = (i_addr == `ACS_OFF_CAP_LOW);
assign hit_freq0 = (i_addr == `ACS_OFF_FREQ_BYTE0);
assign hit_freq1 = (i_addr == `ACS_OFF_FREQ_BYTE1);
assign hit_freq2 = (i_addr == `ACS_OFF_FREQ_BYTE2);

////////////////////////////////////////////////////////////////////////////////
// byte write enables
// no write enable for capture bytes
assign wr_freq0 = i_wr & hit_freq0;
assign wr_freq1 = i_wr & hit_freq1;
assign wr_freq2 = i_wr & hit_freq2;

////////////////////////////////////////////////////////////////////////////////
// capture byte lanes
// low and high byte split
assign cap_low = cap_q[7:0];
assign cap_high = cap_q[15:8];

////////////////////////////////////////////////////////////////////////////////
// capture on start of frame
always @* begin
	cap_d = cap_q;
	if (i_sof) begin
		cap_d = count;
	end
end

always @(posedge i_ref_clk) begin
	if (!i_nrst) begin
		cap_q <= {`ACS_RST_CAP, `ACS_RST_CAP};
		cap_pulse_q <= 1'b0;
	end else begin
		cap_q <= cap_d;
		cap_pulse_q <= i_sof;
	end
end

////////////////////////////////////////////////////////////////////////////////
// frequency word bytes
always @* begin
	freq0_d = freq0_q;
	freq1_d = freq1_q;
	freq2_d = freq2_q;
	freq_load_d = 1'b0;
	if (wr_freq0) begin
		freq0_d = i_wdata;
		freq_load_d = 1'b1;
	end
	if (wr_freq1) begin
		freq1_d = i_wdata;
		freq_load_d = 1'b1;
	end
	if (wr_freq2) begin
		freq2_d = i_wdata;
		freq_load_d = 1'b1;
	end
end

always @(posedge i_ref_clk) begin
	if (!i_nrst) begin
		freq0_q <= `ACS_RST_FREQ;
		freq1_q <= `ACS_RST_FREQ;
		freq2_q <= `ACS_RST_FREQ;
		freq_load_q <= 1'b0;
	end else begin
		freq0_q <= freq0_d;
		freq1_q <= freq1_d;
		freq2_q <= freq2_d;
		freq_load_q <= freq_load_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// read path
always @* begin
	rdata_d = `ACS_RDATA_UNMAPPED;
	if (hit_cap_low) begin
		rdata_d = cap_low;
	end else if (hit_cap_high) begin
		rdata_d = cap_high;
	end else if (hit_freq0) begin
		rdata_d = freq0_q;
	end else if (hit_freq1) begin
		rdata_d = freq1_q;
	end else if (hit_freq2) begin
		rdata_d = freq2_q;
	end
end

// read data held until next read
always @(posedge i_ref_clk) begin
	if (!i_nrst) begin
		rdata_q <= `ACS_RDATA_UNMAPPED;
	end else if (i_rd) begin
		rdata_q <= rdata_d;
	end
end

// read valid one cycle after strobe
always @(posedge i_ref_clk) begin
	if (!i_nrst) begin
		rvalid_q <= 1'b0;
	end else begin
		rvalid_q <= i_rd;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs
assign o_rdata = rdata_q;
assign o_rvalid = rvalid_q;
assign o_frequency_word = {freq2_q, freq1_q, freq0_q};
assign o_freq_load = freq_load_q;
assign o_captured_count = cap_q;
assign o_capture_pulse = cap_pulse_q;
assign o_mclk_tick = tick;

endmodule

// [tb/acs_cap_assertions.sv]
// port checker for the sof capture block
`timescale 1ns/1ps
module acs_cap_chk #(parameter CNT_W = 16, parameter FREQ_W = 24) (
	input wire i_ref_clk, i_nrst, i_mclk_one, i_mclk_two, i_cnt_sel, i_sof, i_wr, i_rd,
	input wire [15:0] i_addr,
	input wire [7:0] i_wdata, o_rdata,
	input wire o_rvalid, o_freq_load, o_capture_pulse, o_mclk_tick,
	input wire [FREQ_W-1:0] o_frequency_word,
	input wire [CNT_W-1:0] o_captured_count
);
default clocking @(posedge i_ref_clk); endclocking
default disable iff (!i_nrst);
property p_cap; i_sof |=> o_capture_pulse; endproperty
a_cap: assert property (p_cap) else $error("no capture pulse");
property p_hold; !i_sof |=> $stable(o_captured_count); endproperty
a_hold: assert property (p_hold) else $error("capture moved");
property p_cnt; i_sof ##1 i_sof |=>
	o_captured_count - $past(o_captured_count) == CNT_W'($past(o_mclk_tick, 2)); endproperty
a_cnt: assert property (p_cnt) else $error("count step wrong");
property p_tick; o_mclk_tick |-> (i_cnt_sel ? i_mclk_two : i_mclk_one); endproperty
a_tick: assert property (p_tick) else $error("tick from wrong clock");
property p_low; i_rd && i_addr == 16'hffe4 |=>
	o_rvalid && o_rdata == $past(o_captured_count[7:0]); endproperty
a_low: assert property (p_low) else $error("low byte read");
property p_high; i_rd && i_addr == 16'hffe3 |=>
	o_rvalid && o_rdata == $past(o_captured_count[15:8]); endproperty
a_high: assert property (p_high) else $error("high byte read");
property p_b0; i_wr && i_addr == 16'hfff9 |=>
	o_freq_load && o_frequency_word[7:0] == $past(i_wdata); endproperty
a_b0: assert property (p_b0) else $error("byte0 write");
property p_b2; i_wr && i_addr == 16'hfff7 |=>
	o_freq_load && o_frequency_word[23:16] == $past(i_wdata); endproperty
a_b2: assert property (p_b2) else $error("byte2 write");
c_two: cover property (i_sof ##1 i_sof);
c_sel: cover property (o_mclk_tick && i_cnt_sel);
c_rd: cover property (i_rd && i_addr == 16'hffe3);
endmodule
bind acs_sof_capture acs_cap_chk #(.CNT_W(CNT_W), .FREQ_W(FREQ_W)) u_chk (.*);

// [tb/acs_frame_src.sv]
// usb engine model issuing start of frame pulses
`timescale 1ns/1ps
module acs_frame_src (
	input wire i_clk,
	input wire i_go,
	input wire [1:0] i_len,
	output reg o_sof
);
reg [1:0] left_q = 2'h0;
initial o_sof = 1'b0;
always @(negedge i_clk) begin
	o_sof <= left_q != 2'h0;
	if (left_q != 2'h0) left_q <= left_q - 2'h1;
end
always @(posedge i_clk) if (i_go) left_q <= i_len;
endmodule

// [tb/tb.sv]
// testbench for the sof capture block
`timescale 1ns/1ps
module tb;
reg i_ref_clk = 0, i_nrst = 0, i_mclk_one = 0, i_mclk_two = 0, i_cnt_sel = 0;
reg i_wr = 0, i_rd = 0, go = 0, p1 = 0, p2 = 0;
reg [1:0] len = 1;
reg [15:0] i_addr = 0, cnt = 0, mcap = 0;
reg [7:0] i_wdata = 0;
integer err_total = 0, n_tests = 0;
wire i_sof, o_rvalid, o_freq_load, o_capture_pulse, o_mclk_tick;
wire [7:0] o_rdata;
wire [23:0] o_frequency_word;
wire [15:0] o_captured_count;
acs_frame_src u_src (.i_clk(i_ref_clk), .i_go(go), .i_len(len), .o_sof(i_sof));
acs_sof_capture u_dut (.*);
always #20 i_ref_clk = ~i_ref_clk;
always begin repeat (3) @(negedge i_ref_clk); i_mclk_one = ~i_mclk_one; end
always begin repeat (5) @(negedge i_ref_clk); i_mclk_two = ~i_mclk_two; end
////////////////////////////////////////////////////////////////
// reference count
always @(posedge i_ref_clk) begin
	if (!i_nrst) begin
		cnt <= 0;
		mcap <= 0;
	end else begin
		if (i_sof) mcap <= cnt;
		if (i_cnt_sel ? i_mclk_two && !p2 : i_mclk_one && !p1) cnt <= cnt + 16'h1;
	end
	p1 <= i_nrst & i_mclk_one;
	p2 <= i_nrst & i_mclk_two;
end
////////////////////////////////////////////////////////////////
task chk(input string nm, input [23:0] e, input [23:0] g);
	n_tests++;
	if (e !== g) begin
		err_total++;
		$display("[FAIL] %s exp %h got %h", nm, e, g);
	end
endtask
task wr_b(input [15:0] a, input [7:0] d);
	@(negedge i_ref_clk);
	i_addr = a;
	i_wdata = d;
	i_wr = 1;
	@(negedge i_ref_clk);
	i_wr = 0;
endtask
task rd_b(input [15:0] a, input [7:0] e, input string nm);
	@(negedge i_ref_clk);
	i_addr = a;
	i_rd = 1;
	@(negedge i_ref_clk);
	i_rd = 0;
	chk(nm, {16'h0, e}, {16'h0, o_rdata});
endtask
task t_reset;
	rd_b(16'hffe3, 8'h00, "cap_high");
	rd_b(16'hffe4, 8'h00, "cap_low");
	rd_b(16'hfff7, 8'h00, "freq2");
	rd_b(16'hfff8, 8'h00, "freq1");
	rd_b(16'hfff9, 8'h00, "freq0");
	rd_b(16'hffe5, 8'h00, "unmapped");
endtask
task t_freq;
	wr_b(16'hfff9, 8'ha5);
	wr_b(16'hfff8, 8'h3c);
	wr_b(16'hfff7, 8'hc3);
	wr_b(16'hffe3, 8'hff);
	chk("freq_word", 24'hc3_3ca5, o_frequency_word);
	rd_b(16'hfff9, 8'ha5, "freq0");
	rd_b(16'hfff8, 8'h3c, "freq1");
	rd_b(16'hfff7, 8'hc3, "freq2");
	rd_b(16'hffe3, 8'h00, "cap_high");
endtask
task t_cap(input s, input [1:0] l);
	i_cnt_sel = s;
	len = l;
	@(negedge i_ref_clk);
	go = 1;
	@(negedge i_ref_clk);
	go = 0;
	repeat (6) @(negedge i_ref_clk);
	rd_b(16'hffe4, mcap[7:0], "cap_low");
	rd_b(16'hffe3, mcap[15:8], "cap_high");
endtask
task wrap_up;
	if (err_total == 0 && n_tests > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
initial begin
	#800_000;
	err_total++;
	wrap_up;
end
initial begin
	repeat (10) @(negedge i_ref_clk);
	i_nrst = 1;
	t_reset;
	t_freq;
	repeat (3000) @(negedge i_ref_clk);
	t_cap(0, 1);
	t_cap(1, 2);
	t_cap(0, 2);
	wrap_up;
end
endmodule
